// ==== design/rstic_pkg.sv ====
package rstic_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] ENABLE_REG_LOW_ADDR  = 8'h3a;
    localparam logic [7:0] ENABLE_REG_HIGH_ADDR = 8'h3b;
    localparam logic [7:0] LATCH_LOW_ADDR       = 8'h3c;
    localparam logic [7:0] LATCH_HIGH_ADDR      = 8'h3d;
    localparam logic [7:0] SYS_CTRL_TWO_ADDR    = 8'h38;
    localparam logic [7:0] WDOG_CTRL_ONE_ADDR   = 8'h34;
    localparam logic [7:0] SHARED_SEL_ADDR      = 8'h4a;

    // field positions
    localparam int MASTER_EN_BIT   = 0;
    localparam int XEN_BIT         = 7;
    localparam int XTEN_BIT        = 6;
    localparam int SYSCK_BIT       = 5;
    localparam int RAM_TRAP_BIT    = 3;
    localparam int TRAP_RESP_BIT   = 2;
    localparam int WDOG_RESP_BIT   = 1;
    localparam int L14_SEL_BIT     = 0;
    localparam int L15_SEL_BIT     = 1;

    // reset values
    localparam logic [7:0] SYS_CTRL_TWO_RST  = 8'hc0;
    localparam logic [7:0] WDOG_CTRL_ONE_RST = 8'h06;

    // timing: main clock periods
    localparam int FAULT_RESET_CYCLES = 24;
    localparam int EXT_RESET_MIN_CYC  = 12;

    // vectors
    localparam logic [15:0] RESET_VECTOR = 16'hfffe;
    localparam logic [15:0] SOFT_VECTOR  = 16'hfffc;
    localparam logic [15:0] TRAP_VECTOR  = 16'hfffa;
    localparam logic [15:0] WDOG_VECTOR  = 16'hfff8;
    localparam logic [15:0] LAST_VECTOR  = 16'hfff6;

    typedef enum logic [1:0]
    {
        RS_RUN   = 2'b00,
        RS_FAULT = 2'b01,
        RS_EXT   = 2'b10
    } rstic_rst_t;

    typedef struct packed
    {
        rstic_rst_t  rst_state;
        logic [4:0]  rst_cnt;
        logic [4:0]  ext_cnt;
        logic        core_reset;
        logic        pin_low;
        logic        master_irq_enable;
        logic [15:0] source_enable_flags;
        logic [15:0] pending_latches;
        logic [7:0]  system_control_two;
        logic [7:0]  watchdog_control_one;
        logic [7:0]  shared_level_selector;
        logic [7:0]  rdata;
        logic        irq_req;
        logic [15:0] irq_vector;
        logic        prescaler_clr;
        logic        wdog_enable;
    } rstic_state_t;

endpackage

// ==== design/rstic_top.sv ====
// Overview of operation
// [RQ1] fault reset holds core reset and pin low at most 24 clocks; here the pin is low 24 clocks and core reset stays 25
// [RQ2] power-up fault pulse, also at most 24 clocks
// [RQ3] reset zeroes master enable, source enables and pending latches
// [RQ4] reset clears prescaler, enables watchdog; cpu state left alone
// [RQ5] pin held low 12 clocks applies and initialises reset
// [RQ6] pin release frees reset and reports start vector fffe
// [RQ7] fetch from sfr, buffer, or trapped ram raises address trap
// [RQ8] trap resets until its response select is cleared
// [RQ9] watchdog resets until its response select is cleared
// [RQ10] bad oscillator disable combinations trigger system clock reset
// [RQ11] clock reset keeps both oscillators running
// [RQ12] eighteen sources, two shared levels, four non-maskable
// [RQ13] pending latch set on request, held until accepted
// [RQ14] maskable accept needs master and own enable; ext0 also pin function
// [RQ15] fixed priority, lowest latch index first, nesting allowed
// [RQ16] non-maskable sources share top priority, ignore enables
// [RQ17] soft/undefined vector fffc, trap latch 2 fffa, watchdog latch 3 fff8
// [RQ18] latches 4..15 vectors fff6 down by two to ffe0
// [RQ19] levels 14 and 15 pick source by select bit
// [RQ20] accepted source latch cleared at once
// [RQ21] accept saves and clears master enable; return restores it
// [RQ22] master enable at bit 0 of register 3a
`timescale 1ns/10ps
`default_nettype none
module rstic_top
    import rstic_pkg::*;
(
    // clock and reset
    input  wire  logic              clk_i,
    input  wire  logic              reset_i,
    // reset pin (open drain)
    input  wire  logic              reset_pin_n_i,
    output logic                    reset_pin_o,
    output logic                    reset_pin_oe_o,
    // register port
    input  wire  logic [ADDR_W-1:0] addr_i,
    input  wire  logic [DATA_W-1:0] wdata_i,
    input  wire  logic              wr_i,
    input  wire  logic              rd_i,
    output logic       [DATA_W-1:0] rdata_o,
    // cpu side
    input  wire  logic [15:0]       fetch_addr_i,
    input  wire  logic              fetch_i,
    input  wire  logic              fetch_in_sfr_i,
    input  wire  logic              fetch_in_dbr_i,
    input  wire  logic              fetch_in_ram_i,
    input  wire  logic              software_irq_i,
    input  wire  logic              undefined_opcode_irq_i,
    input  wire  logic              irq_ack_i,
    input  wire  logic              return_from_irq_i,
    input  wire  logic              saved_master_i,
    output logic                    core_reset_o,
    output logic                    irq_req_o,
    output logic       [15:0]       irq_vector_o,
    output logic                    saved_master_o,
    // peripherals and pins
    input  wire  logic              watchdog_timeout_i,
    input  wire  logic              ext0_pin_function_on_i,
    input  wire  logic              ext_irq_zero_i,
    input  wire  logic              ext_irq_one_i,
    input  wire  logic              time_base_irq_i,
    input  wire  logic              timer_one_irq_i,
    input  wire  logic              ext_irq_two_i,
    input  wire  logic              timer_four_irq_i,
    input  wire  logic              timer_three_irq_i,
    input  wire  logic              ext_irq_three_i,
    input  wire  logic              sync_serial_irq_i,
    input  wire  logic              receive_irq_i,
    input  wire  logic              ext_irq_four_i,
    input  wire  logic              transmit_irq_i,
    input  wire  logic              ext_irq_five_i,
    input  wire  logic              converter_done_irq_i,
    output logic                    xen_o,
    output logic                    xten_o,
    output logic                    sysck_o,
    output logic                    prescaler_clr_o,
    output logic                    wdog_enable_o
);

    rstic_state_t st_ff;
    rstic_state_t nxt_st;

    // vector of latch index n: fff6 minus two per step above 4
    function automatic logic [15:0] latch_vector(input logic [3:0] idx);
        return LAST_VECTOR - {11'h000, (idx - 4'h4), 1'b0};
    endfunction

    // lowest set bit index, 0 when none
    function automatic logic [3:0] first_set(input logic [15:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (m[i])
                r = 4'(i);
        end
        return r;
    endfunction

    logic [15:0] raw_req;
    logic        trap_hit;
    logic        clk_fault;
    logic        trap_as_reset;
    logic        wdog_as_reset;
    logic        fault_req;
    logic [15:0] enabled;
    logic [3:0]  win;

    // request sources
    always_comb
    begin
        trap_hit = fetch_i & (fetch_in_sfr_i | fetch_in_dbr_i
                   | (fetch_in_ram_i & st_ff.watchdog_control_one[RAM_TRAP_BIT])); // RQ7
        trap_as_reset = trap_hit & st_ff.watchdog_control_one[TRAP_RESP_BIT]; // RQ8
        wdog_as_reset = watchdog_timeout_i & st_ff.watchdog_control_one[WDOG_RESP_BIT]; // RQ9
        clk_fault = 1'b0;
        if (wr_i && addr_i == SYS_CTRL_TWO_ADDR)
        begin
            // three illegal oscillator-stop cases
            clk_fault = (!wdata_i[XEN_BIT] && !wdata_i[XTEN_BIT])
                        || (!wdata_i[XEN_BIT] && !st_ff.system_control_two[SYSCK_BIT])
                        || (!wdata_i[XTEN_BIT] && st_ff.system_control_two[SYSCK_BIT]); // RQ10
        end
        fault_req = trap_as_reset | wdog_as_reset | clk_fault;
        raw_req = '0;
        raw_req[2]  = trap_hit & ~st_ff.watchdog_control_one[TRAP_RESP_BIT];
        raw_req[3]  = watchdog_timeout_i & ~st_ff.watchdog_control_one[WDOG_RESP_BIT];
        raw_req[4]  = ext_irq_zero_i;
        raw_req[5]  = ext_irq_one_i;
        raw_req[6]  = time_base_irq_i;
        raw_req[7]  = timer_one_irq_i;
        raw_req[8]  = ext_irq_two_i;
        raw_req[9]  = timer_four_irq_i;
        raw_req[10] = timer_three_irq_i;
        raw_req[11] = ext_irq_three_i;
        raw_req[12] = sync_serial_irq_i;
        raw_req[13] = receive_irq_i;
        raw_req[14] = st_ff.shared_level_selector[L14_SEL_BIT] ? transmit_irq_i : ext_irq_four_i; // RQ19
        raw_req[15] = st_ff.shared_level_selector[L15_SEL_BIT] ? converter_done_irq_i
                                                                : ext_irq_five_i; // RQ19
    end

    // acceptance gating and priority
    always_comb
    begin
        enabled = st_ff.pending_latches
                  & (st_ff.source_enable_flags & {16{st_ff.master_irq_enable}}); // RQ14
        enabled[4] = enabled[4] & ext0_pin_function_on_i; // RQ14
        enabled[3:2] = st_ff.pending_latches[3:2]; // RQ16
        enabled[1:0] = 2'b00;
        win = first_set(enabled); // RQ15
    end

    // next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        nxt_st.prescaler_clr = 1'b0;

        // reset sequencer
        case (st_ff.rst_state)
            RS_RUN:
            begin
                if (fault_req)
                begin
                    nxt_st.rst_state = RS_FAULT;
                    nxt_st.rst_cnt = 5'(FAULT_RESET_CYCLES - 1);
                    nxt_st.core_reset = 1'b1; // RQ1
                    nxt_st.pin_low = 1'b1; // RQ1
                end
            end
            RS_FAULT:
            begin
                // bounded pulse, then let the pin float back up
                if (st_ff.rst_cnt == 5'h00)
                begin
                    nxt_st.pin_low = 1'b0;
                    nxt_st.rst_state = RS_EXT;
                end
                else
                    nxt_st.rst_cnt = st_ff.rst_cnt - 5'h01; // RQ1 RQ11
            end
            RS_EXT:
            begin
                if (reset_pin_n_i)
                    nxt_st.rst_state = RS_RUN;
            end
            default:
                nxt_st.rst_state = RS_RUN;
        endcase

        // external pin filter: counts 12 low clocks, reset applies on the 13th
        if (!reset_pin_n_i)
        begin
            if (st_ff.ext_cnt < 5'(EXT_RESET_MIN_CYC))
                nxt_st.ext_cnt = st_ff.ext_cnt + 5'h01;
            else
                nxt_st.core_reset = 1'b1; // RQ5
        end
        else
        begin
            nxt_st.ext_cnt = '0;
            if (st_ff.rst_state != RS_FAULT && st_ff.core_reset)
                nxt_st.core_reset = 1'b0; // RQ6
        end

        if (st_ff.core_reset)
        begin
            // initialise everything this block owns
            nxt_st.master_irq_enable = 1'b0; // RQ3
            nxt_st.source_enable_flags = '0; // RQ3
            nxt_st.pending_latches = '0; // RQ3
            nxt_st.watchdog_control_one = WDOG_CTRL_ONE_RST; // RQ8 RQ9
            nxt_st.system_control_two = SYS_CTRL_TWO_RST;
            nxt_st.shared_level_selector = '0;
            nxt_st.prescaler_clr = 1'b1; // RQ4
            nxt_st.wdog_enable = 1'b1; // RQ4
            nxt_st.irq_req = 1'b0;
            nxt_st.irq_vector = RESET_VECTOR; // RQ6
        end
        else
        begin
            // software writes
            if (wr_i)
            begin
                case (addr_i)
                    ENABLE_REG_LOW_ADDR:
                    begin
                        nxt_st.master_irq_enable = wdata_i[MASTER_EN_BIT]; // RQ22
                        nxt_st.source_enable_flags[7:4] = wdata_i[7:4];
                    end
                    ENABLE_REG_HIGH_ADDR: nxt_st.source_enable_flags[15:8] = wdata_i;
                    // latches clear only, software cannot set them
                    LATCH_LOW_ADDR:
                        nxt_st.pending_latches[7:2] = st_ff.pending_latches[7:2] & wdata_i[7:2];
                    LATCH_HIGH_ADDR:
                        nxt_st.pending_latches[15:8] = st_ff.pending_latches[15:8] & wdata_i;
                    SYS_CTRL_TWO_ADDR:
                    begin
                        // a faulting write is dropped so oscillators keep running
                        if (!clk_fault)
                            nxt_st.system_control_two = wdata_i; // RQ11
                    end
                    WDOG_CTRL_ONE_ADDR: nxt_st.watchdog_control_one = wdata_i;
                    SHARED_SEL_ADDR: nxt_st.shared_level_selector = wdata_i;
                    default: ;
                endcase
            end

            // acceptance
            if (irq_ack_i && st_ff.irq_req)
            begin
                if (st_ff.irq_vector != SOFT_VECTOR)
                    nxt_st.pending_latches[win] = 1'b0; // RQ20
                nxt_st.master_irq_enable = 1'b0; // RQ21
            end
            else if (return_from_irq_i)
                nxt_st.master_irq_enable = saved_master_i; // RQ21

            // new requests win over clears in the same cycle
            nxt_st.pending_latches = nxt_st.pending_latches | raw_req; // RQ13

            // request to the cpu; soft and undefined have no latch
            nxt_st.irq_req = (|enabled) | software_irq_i | undefined_opcode_irq_i; // RQ12
            if (software_irq_i || undefined_opcode_irq_i)
                nxt_st.irq_vector = SOFT_VECTOR; // RQ17
            else if (win == 4'h2)
                nxt_st.irq_vector = TRAP_VECTOR; // RQ17
            else if (win == 4'h3)
                nxt_st.irq_vector = WDOG_VECTOR; // RQ17
            else
                nxt_st.irq_vector = latch_vector(win); // RQ18
        end

        // read data, one cycle later
        if (rd_i)
        begin
            case (addr_i)
                ENABLE_REG_LOW_ADDR:
                    nxt_st.rdata = {st_ff.source_enable_flags[7:4], 3'b000, st_ff.master_irq_enable};
                ENABLE_REG_HIGH_ADDR: nxt_st.rdata = st_ff.source_enable_flags[15:8];
                LATCH_LOW_ADDR:       nxt_st.rdata = {st_ff.pending_latches[7:2], 2'b00};
                LATCH_HIGH_ADDR:      nxt_st.rdata = st_ff.pending_latches[15:8];
                SYS_CTRL_TWO_ADDR:    nxt_st.rdata = st_ff.system_control_two;
                WDOG_CTRL_ONE_ADDR:   nxt_st.rdata = st_ff.watchdog_control_one;
                SHARED_SEL_ADDR:      nxt_st.rdata = st_ff.shared_level_selector;
                default:              nxt_st.rdata = '0;
            endcase
        end
    end

    // state register; power-on reset clears it, loads the control register and vector reset values, and starts the fault pulse in RS_FAULT
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_ff <= '0;
            st_ff.core_reset <= 1'b1; // RQ2
            st_ff.rst_state <= RS_FAULT; // RQ2
            st_ff.rst_cnt <= 5'(FAULT_RESET_CYCLES - 1); // RQ2
            st_ff.pin_low <= 1'b1; // RQ2
            st_ff.irq_vector <= RESET_VECTOR;
            st_ff.watchdog_control_one <= WDOG_CTRL_ONE_RST;
            st_ff.system_control_two <= SYS_CTRL_TWO_RST;
            st_ff.wdog_enable <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from flops, except reset_pin_o which is tied low
    assign reset_pin_o     = 1'b0;
    assign reset_pin_oe_o  = st_ff.pin_low;
    assign rdata_o         = st_ff.rdata;
    assign core_reset_o    = st_ff.core_reset;
    assign irq_req_o       = st_ff.irq_req;
    assign irq_vector_o    = st_ff.irq_vector;
    assign saved_master_o  = st_ff.master_irq_enable;
    assign xen_o           = st_ff.system_control_two[XEN_BIT];
    assign xten_o          = st_ff.system_control_two[XTEN_BIT];
    assign sysck_o         = st_ff.system_control_two[SYSCK_BIT];
    assign prescaler_clr_o = st_ff.prescaler_clr;
    assign wdog_enable_o   = st_ff.wdog_enable;

endmodule
`default_nettype wire

// ==== bench/rstic_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module rstic_monitor
    import rstic_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // reset pin
    input  wire logic              reset_pin_n_i,
    input  wire logic              reset_pin_oe_o,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    // cpu side
    input  wire logic              software_irq_i,
    input  wire logic              irq_ack_i,
    input  wire logic              return_from_irq_i,
    input  wire logic              saved_master_i,
    input  wire logic              core_reset_o,
    input  wire logic              irq_req_o,
    input  wire logic [15:0]       irq_vector_o,
    input  wire logic              saved_master_o,
    // oscillator control
    input  wire logic              xen_o,
    input  wire logic              xten_o,
    input  wire logic              sysck_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic [5:0] oe_cnt_ff;
    logic [3:0] low_cnt_ff;

    // pin run lengths; saturate so they never wrap under a limit
    always_ff @(posedge clk_i)
    begin
        oe_cnt_ff <= (reset_i || !reset_pin_oe_o) ? 6'h00 : oe_cnt_ff + {5'h00, oe_cnt_ff != 6'h3f};
        low_cnt_ff <= (reset_i || reset_pin_n_i) ? 4'h0 : low_cnt_ff + {3'h0, low_cnt_ff != 4'hf};
    end

    property p_pulse_len; oe_cnt_ff <= 6'h18; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pin pulse too long");
    property p_pin_core; reset_pin_oe_o |-> ##[0:1] core_reset_o; endproperty
    a_pin_core: assert property (p_pin_core) else $error("pin without reset");
    property p_ext_apply; low_cnt_ff == 4'hc |-> ##[0:3] core_reset_o; endproperty
    a_ext_apply: assert property (p_ext_apply) else $error("pin did not reset");
    property p_release; $rose(reset_pin_n_i) && core_reset_o |-> ##[1:2] !core_reset_o; endproperty
    a_release: assert property (p_release) else $error("reset not released");
    property p_soft; software_irq_i && !core_reset_o |-> ##[1:2] (irq_req_o && irq_vector_o == SOFT_VECTOR); endproperty
    a_soft: assert property (p_soft) else $error("soft request lost");
    property p_ack; irq_ack_i && !core_reset_o |=> !saved_master_o; endproperty
    a_ack: assert property (p_ack) else $error("master kept on accept");
    property p_ret; return_from_irq_i && !core_reset_o |=> saved_master_o == $past(saved_master_i); endproperty
    a_ret: assert property (p_ret) else $error("master not restored");
    property p_master_wr;
        wr_i && addr_i == ENABLE_REG_LOW_ADDR && !core_reset_o && !irq_ack_i && !return_from_irq_i
            |=> saved_master_o == $past(wdata_i[MASTER_EN_BIT]);
    endproperty
    a_master_wr: assert property (p_master_wr) else $error("master write lost");
    property p_xen_kept; $fell(xen_o) |-> $past(sysck_o) && xten_o; endproperty
    a_xen_kept: assert property (p_xen_kept) else $error("running oscillator stopped");
    property p_xten_kept; $fell(xten_o) |-> !$past(sysck_o) && xen_o; endproperty
    a_xten_kept: assert property (p_xten_kept) else $error("low osc stopped in use");

    // main scenarios reached
    c_accept: cover property (irq_ack_i && irq_req_o);
    c_reset: cover property ($rose(core_reset_o));
    c_return: cover property (return_from_irq_i && saved_master_i);
endmodule

bind rstic_top rstic_monitor u_rstic_monitor (.clk_i, .reset_i, .reset_pin_n_i, .reset_pin_oe_o, .addr_i, .wdata_i,
    .wr_i, .software_irq_i, .irq_ack_i, .return_from_irq_i, .saved_master_i, .core_reset_o, .irq_req_o,
    .irq_vector_o, .saved_master_o, .xen_o, .xten_o, .sysck_o);
`default_nettype wire

// ==== bench/rstic_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rstic_pin_model
(
    // device side of the open-drain pin
    input  wire logic pin_drive_i,
    input  wire logic pin_oe_i,
    // external reset source
    input  wire logic hold_low_i,
    // resolved pin level
    output logic      pin_n_o
);
    // pull-up wins only when nobody pulls low
    assign pin_n_o = !((pin_oe_i && !pin_drive_i) || hold_low_i);
endmodule
`default_nettype wire

// ==== bench/test_reset_and_interrupt_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_reset_and_interrupt_control;
    import rstic_pkg::*;
    logic        clk_i, reset_i, hold_low, pin_n, pin_drv, pin_oe, wr_i, rd_i, fetch_i, irq_ack_i, ret_i;
    logic        smi_i, wdt_i, ext0on_i, core_rst, req, smo, xen, xten, sysck, pclr, wden;
    logic [7:0]  addr_i, wdata_i, rdata_o;
    logic [2:0]  region;
    logic [1:0]  nmi;
    logic [13:0] src;
    logic [15:0] vec;
    int          fail_count, total_checks, n, lat;

    rstic_top u_rstic_top (.clk_i, .reset_i, .reset_pin_n_i(pin_n), .reset_pin_o(pin_drv),
        .reset_pin_oe_o(pin_oe), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .fetch_addr_i(16'h0000), .fetch_i, .fetch_in_sfr_i(region[0]), .fetch_in_dbr_i(region[1]),
        .fetch_in_ram_i(region[2]), .software_irq_i(nmi[0]), .undefined_opcode_irq_i(nmi[1]),
        .irq_ack_i, .return_from_irq_i(ret_i), .saved_master_i(smi_i), .core_reset_o(core_rst),
        .irq_req_o(req), .irq_vector_o(vec), .saved_master_o(smo), .watchdog_timeout_i(wdt_i),
        .ext0_pin_function_on_i(ext0on_i), .ext_irq_zero_i(src[0]), .ext_irq_one_i(src[1]),
        .time_base_irq_i(src[2]), .timer_one_irq_i(src[3]), .ext_irq_two_i(src[4]), .timer_four_irq_i(src[5]),
        .timer_three_irq_i(src[6]), .ext_irq_three_i(src[7]), .sync_serial_irq_i(src[8]),
        .receive_irq_i(src[9]), .ext_irq_four_i(src[10]), .transmit_irq_i(src[11]), .ext_irq_five_i(src[12]),
        .converter_done_irq_i(src[13]), .xen_o(xen), .xten_o(xten), .sysck_o(sysck), .prescaler_clr_o(pclr),
        .wdog_enable_o(wden));
    rstic_pin_model u_rstic_pin_model (.pin_drive_i(pin_drv), .pin_oe_i(pin_oe), .hold_low_i(hold_low),
        .pin_n_o(pin_n));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait: 0 request, 1 core reset
    task wait_for(input int which, input logic lvl);
        int k;
        k = 0;
        #1;
        while (((which == 0) ? req : core_rst) !== lvl)
        begin
            @(posedge clk_i);
            #1;
            k++;
            if (k > 60)
            begin
                $display("mismatch wait %0d expected %b seen timeout", which, lvl);
                fail_count++;
                wrap_up();
            end
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand one cycle only
    task rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, {8'h00, rdata_o}, {8'h00, e});
    endtask

    // one-cycle event: 0 watchdog, 1-2 soft/undefined, 3-5 fetch sfr/dbr/ram, 6 ack, 7 return, else sources
    task kick(input int k, input logic [13:0] m = 14'h0000);
        @(posedge clk_i);
        case (k)
            0: wdt_i <= 1'b1;
            1: nmi <= 2'b01;
            2: nmi <= 2'b10;
            3, 4, 5: fetch_i <= 1'b1;
            6: irq_ack_i <= 1'b1;
            7: ret_i <= 1'b1;
            default: src <= m;
        endcase
        region <= (k >= 3 && k <= 5) ? 3'(1 << (k - 3)) : 3'h0;
        @(posedge clk_i);
        {wdt_i, nmi, fetch_i, irq_ack_i, ret_i, region, src} <= 23'h000000;
    endtask

    initial
    begin
        {reset_i, hold_low, wr_i, rd_i, fetch_i, irq_ack_i, ret_i, smi_i, wdt_i, ext0on_i} = 10'h204;
        {addr_i, wdata_i, region, nmi, src} = 35'h0;
        fail_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        // power-up pulse, then reset values
        @(posedge clk_i);
        #1;
        check("reset vector", vec, RESET_VECTOR);
        check("prescaler", pclr, 1'b1);
        check("watchdog on", wden, 1'b1);
        n = 0;
        while (pin_oe === 1'b1 && n < 30)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("pulse len", n <= 24, 1'b1);
        wait_for(1, 1'b0);
        rdchk("enable low", ENABLE_REG_LOW_ADDR, 8'h00);
        rdchk("enable high", ENABLE_REG_HIGH_ADDR, 8'h00);
        rdchk("latch low", LATCH_LOW_ADDR, 8'h00);
        rdchk("latch high", LATCH_HIGH_ADDR, 8'h00);
        rdchk("sys control", SYS_CTRL_TWO_ADDR, SYS_CTRL_TWO_RST);
        rdchk("wdog control", WDOG_CTRL_ONE_ADDR, WDOG_CTRL_ONE_RST);
        wr(ENABLE_REG_LOW_ADDR, 8'h01);
        rdchk("master", ENABLE_REG_LOW_ADDR, 8'h01);
        // each maskable source and shared choice
        ext0on_i <= 1'b1;
        wr(ENABLE_REG_HIGH_ADDR, 8'hff);
        for (int i = 0; i < 14; i++)
        begin
            lat = (i < 10) ? i + 4 : ((i < 12) ? 14 : 15);
            wr(SHARED_SEL_ADDR, (i == 11) ? 8'h01 : ((i == 13) ? 8'h02 : 8'h00));
            wr(ENABLE_REG_LOW_ADDR, 8'hf1);
            kick(8, 14'h0001 << i);
            wait_for(0, 1'b1);
            check("vector", vec, 16'hfff6 - 16'(2 * (lat - 4)));
            kick(6);
            #1;
            check("master on ack", smo, 1'b0);
            rdchk("latch clear", (lat < 8) ? LATCH_LOW_ADDR : LATCH_HIGH_ADDR, 8'h00);
        end
        // masking, priority, return restoring master
        wr(ENABLE_REG_HIGH_ADDR, 8'h02);
        wr(ENABLE_REG_LOW_ADDR, 8'h20);
        kick(8, 14'h0022);
        repeat (3) @(posedge clk_i);
        #1;
        check("masked", req, 1'b0);
        rdchk("held latch", LATCH_LOW_ADDR, 8'h20);
        wr(ENABLE_REG_LOW_ADDR, 8'h21);
        wait_for(0, 1'b1);
        check("first served", vec, 16'hfff4);
        kick(6);
        kick(7);
        wait_for(0, 1'b1);
        check("second served", vec, 16'hffec);
        kick(6);
        // non-maskable with master off, then untrapped ram and ext0 pin function off
        for (int k = 1; k < 3; k++)
        begin
            kick(k);
            wait_for(0, 1'b1);
            check("soft vector", vec, SOFT_VECTOR);
            kick(6);
        end
        wr(WDOG_CTRL_ONE_ADDR, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            kick(k * 3);
            wait_for(0, 1'b1);
            check("nmi vector", vec, (k == 1) ? TRAP_VECTOR : WDOG_VECTOR);
            check("no reset", core_rst, 1'b0);
            kick(6);
        end
        kick(5);
        repeat (3) @(posedge clk_i);
        #1;
        check("ram untrapped", {core_rst, req}, 2'b00);
        ext0on_i <= 1'b0;
        wr(ENABLE_REG_LOW_ADDR, 8'h11);
        kick(8, 14'h0001);
        repeat (3) @(posedge clk_i);
        #1;
        check("ext0 off", req, 1'b0);
        // each fault reset kind
        wr(WDOG_CTRL_ONE_ADDR, WDOG_CTRL_ONE_RST);
        for (int k = 0; k < 7; k++)
        begin
            wr(ENABLE_REG_LOW_ADDR, 8'h01);
            if (k == 3)
                wr(WDOG_CTRL_ONE_ADDR, 8'h0e);
            if (k == 6)
                wr(SYS_CTRL_TWO_ADDR, 8'he0);
            case (k)
                0, 1, 2: kick(k == 0 ? 0 : k + 2);
                3: kick(5);
                4: wr(SYS_CTRL_TWO_ADDR, 8'h40);
                5: wr(SYS_CTRL_TWO_ADDR, 8'h00);
                default: wr(SYS_CTRL_TWO_ADDR, 8'ha0);
            endcase
            wait_for(1, 1'b1);
            check("pin pulled", pin_oe, 1'b1);
            check("osc kept", {xen, xten}, 2'b11);
            wait_for(1, 1'b0);
            rdchk("master cleared", ENABLE_REG_LOW_ADDR, 8'h00);
        end
        // pin reset
        wr(ENABLE_REG_LOW_ADDR, 8'h01);
        @(posedge clk_i);
        hold_low <= 1'b1;
        repeat (14) @(posedge clk_i);
        #1;
        check("pin reset", core_rst, 1'b1);
        check("reset vec", vec, RESET_VECTOR);
        @(posedge clk_i);
        hold_low <= 1'b0;
        wait_for(1, 1'b0);
        rdchk("master pin", ENABLE_REG_LOW_ADDR, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
